//--- pds_monitor.sv
// Port checker for the pole detection sequencer
`timescale 1ns/1ps
`default_nettype none
module pds_monitor (
    // Clock, reset and register port
    input wire logic               clock_in,
    input wire logic               rstn_in,
    input wire pds_pkg::pds_bus_s  bus_in,
    input wire logic [31:0]        rdata_out,
    // Controller and stroke ends
    input wire logic               servo_on_cmd_in,
    input wire logic               pos_cmd_in,
    input wire logic               pos_cmd_accept_out,
    input wire logic               servo_ready_out,
    input wire logic               forward_stroke_limit_in,
    input wire logic               reverse_stroke_limit_in,
    // Motion, alarm and interrupt
    input wire pds_pkg::pds_move_s move_out,
    input wire logic               move_done_in,
    input wire logic               pole_detect_fault_alarm_out,
    input wire logic               irq_out
);
    import pds_pkg::*;
    logic stroke_off_r; // Stroke ends ignored during detection
    logic srst_w;       // Soft reset written this cycle
    assign srst_w = bus_in.wr && bus_in.addr == PDS_OFS_CTRL && bus_in.wdata[PDS_CTRL_SRST_BIT];
    // Track the stroke select bit of the control register
    always_ff @(posedge clock_in) begin
        if (!rstn_in)
            stroke_off_r <= PDS_STROKE_RST;
        else if (bus_in.wr && bus_in.addr == PDS_OFS_CTRL)
            stroke_off_r <= bus_in.wdata[PDS_CTRL_STROKE_BIT];
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    a_accept_gate: assert property (pos_cmd_accept_out == (pos_cmd_in && servo_ready_out))
        else $error("command acceptance not tied to servo-lock");
    a_both_off: assert property ((!forward_stroke_limit_in && !reverse_stroke_limit_in
        && !stroke_off_r && servo_on_cmd_in)[*3] ##0 move_out.req |=> pole_detect_fault_alarm_out)
        else $error("both stroke ends off without alarm");
    a_alarm_sticks: assert property (pole_detect_fault_alarm_out && !srst_w |=>
        pole_detect_fault_alarm_out) else $error("alarm cleared without soft reset");
    a_alarm_still: assert property (pole_detect_fault_alarm_out |-> !servo_ready_out
        && !move_out.req) else $error("motion or ready during alarm");
    a_lock_still: assert property (servo_ready_out |-> !move_out.req && !move_out.home)
        else $error("motion during servo-lock");
    a_servo_off: assert property (!servo_on_cmd_in |=> !servo_ready_out && !move_out.req)
        else $error("ready or motion after servo-off");
    a_return_lock: assert property (move_out.home && move_done_in && servo_on_cmd_in
        |=> servo_ready_out || pole_detect_fault_alarm_out) else $error("return not followed by lock");
    a_ready_cause: assert property ($rose(servo_ready_out) |-> $past(move_out.home && move_done_in)
        || $past(servo_on_cmd_in && !move_out.req)) else $error("lock entered mid-detection");
    a_mask_quiet: assert property (bus_in.wr && bus_in.addr == PDS_OFS_IRQ_MSK
        && bus_in.wdata[2:0] == 3'h0 |-> ##2 !irq_out) else $error("interrupt with all masked");
    a_rdata_zero: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
        else $error("read data outside read answer cycle");
endmodule
bind pds_sequencer pds_monitor i_pds_monitor (.clock_in(clock_in), .rstn_in(rstn_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .servo_on_cmd_in(servo_on_cmd_in),
    .pos_cmd_in(pos_cmd_in), .pos_cmd_accept_out(pos_cmd_accept_out),
    .servo_ready_out(servo_ready_out), .forward_stroke_limit_in(forward_stroke_limit_in),
    .reverse_stroke_limit_in(reverse_stroke_limit_in), .move_out(move_out),
    .move_done_in(move_done_in), .pole_detect_fault_alarm_out(pole_detect_fault_alarm_out),
    .irq_out(irq_out));
`default_nettype wire

//--- pds_motion_model.sv
// Motion stage model that ends each commanded leg after a set delay
`timescale 1ns/1ps
`default_nettype none
module pds_motion_model (
    // Clock and reset
    input  wire logic               clock_in,
    input  wire logic               rstn_in,
    // Leg command and answer
    input  wire pds_pkg::pds_move_s move_in,
    input  wire logic [7:0]         delay_in,
    output logic                    move_done_out
);
    import pds_pkg::*;
    logic [7:0] leg_cnt_r; // Cycles spent on the current leg
    // One-cycle done pulse once a leg has run for the delay
    always_ff @(posedge clock_in) begin
        if (!rstn_in || !move_in.req || move_done_out) begin
            leg_cnt_r     <= 8'h00;
            move_done_out <= 1'b0;
        end else begin
            leg_cnt_r     <= leg_cnt_r + 8'h01;
            move_done_out <= (leg_cnt_r + 8'h01 == delay_in);
        end
    end
endmodule
`default_nettype wire

//--- pds_pkg.sv
// Package of constants and types for the pole detection sequencer
//
// Notes on behaviour
// R1: Incremental encoder: detection pending after every reset
// R2: Incremental encoder: detect at servo-on, ignoring policy
// R3: Stroke end drops: continue motion in opposite direction
// R4: Both stroke ends off: raise detection fault alarm
// R5: One end off at servo-on: go to start first
// R6: Reciprocate, return to start, complete, then servo-lock
// R7: Policy: 0 off, 1 first servo-on, 5 always
// R8: Policy 0 after detection skips it at power-up
// R9: Controller checks servo-on status before positioning commands
// R10: Stroke select: 0 limits enabled, 1 disabled
// R11: Ready and command acceptance wait for detection finished
package pds_pkg;
    // Register offsets
    localparam logic [7:0] PDS_OFS_CTRL    = 8'h00;
    localparam logic [7:0] PDS_OFS_STATUS  = 8'h04;
    localparam logic [7:0] PDS_OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] PDS_OFS_IRQ_MSK = 8'h0C;
    // Control field positions
    localparam int PDS_CTRL_POLICY_LSB = 0;
    localparam int PDS_CTRL_STROKE_BIT = 4;
    localparam int PDS_CTRL_ABS_BIT    = 5;
    localparam int PDS_CTRL_SRST_BIT   = 8;
    // Status field positions
    localparam int PDS_ST_STATE_LSB   = 0;
    localparam int PDS_ST_PENDING_BIT = 8;
    localparam int PDS_ST_READY_BIT   = 9;
    localparam int PDS_ST_ALARM_BIT   = 10;
    localparam int PDS_ST_DIR_BIT     = 11;
    // Interrupt bit positions
    localparam int PDS_IRQ_DONE_BIT   = 0;
    localparam int PDS_IRQ_FAULT_BIT  = 1;
    localparam int PDS_IRQ_REV_BIT    = 2;
    localparam int PDS_IRQ_W          = 3;
    // Policy encodings and reset values
    localparam logic [3:0] PDS_POLICY_OFF    = 4'h0;
    localparam logic [3:0] PDS_POLICY_FIRST  = 4'h1;
    localparam logic [3:0] PDS_POLICY_EVERY  = 4'h5;
    localparam logic [3:0] PDS_POLICY_RST    = PDS_POLICY_FIRST;
    localparam logic       PDS_STROKE_EN     = 1'b0;
    localparam logic       PDS_STROKE_RST    = PDS_STROKE_EN;
    localparam logic       PDS_ABS_RST       = 1'b0;
    localparam logic [PDS_IRQ_W-1:0] PDS_IRQ_MSK_RST = 3'h0;
    // Number of back and forth legs during detection
    localparam logic [3:0] PDS_LEGS = 4'h4;

    typedef enum logic [5:0] {
        PDS_IDLE     = 6'h01,
        PDS_TO_START = 6'h02,
        PDS_RECIP    = 6'h04,
        PDS_RETURN   = 6'h08,
        PDS_LOCK     = 6'h10,
        PDS_FAULT    = 6'h20
    } pds_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pds_bus_s;

    typedef struct packed {
        logic req;
        logic dir;
        logic home;
    } pds_move_s;
endpackage

//--- pds_sequencer.sv
// Pole detection sequencer: register slave, sequence control and alarm
`timescale 1ns/1ps
`default_nettype none
module pds_sequencer (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    // Register port
    input  wire pds_pkg::pds_bus_s bus_in,
    output logic [31:0]            rdata_out,
    // Controller side
    input  wire logic              servo_on_cmd_in,
    input  wire logic              pos_cmd_in,
    output logic                   pos_cmd_accept_out,
    output logic                   servo_ready_out,
    // Stroke end pins, high while the stroke end is on
    input  wire logic              forward_stroke_limit_in,
    input  wire logic              reverse_stroke_limit_in,
    // Motion stage
    output pds_pkg::pds_move_s     move_out,
    input  wire logic              move_done_in,
    // Alarm and interrupt
    output logic                   pole_detect_fault_alarm_out,
    output logic                   irq_out
);
    import pds_pkg::*;

    pds_state_e            state_r;
    pds_state_e            state_nxt;
    logic [3:0]            pole_detect_policy_r;
    logic                  pole_detect_stroke_limit_select_r;
    logic                  abs_enc_r;
    logic                  soft_rst;
    logic                  pending_r;
    logic                  dir_r;
    logic [3:0]            legs_r;
    logic                  servo_prev_r;
    logic                  servo_rise;
    logic [1:0]            lim_meta_r;
    logic [1:0]            lim_sync_r;
    logic                  fwd_off;
    logic                  rev_off;
    logic                  need_detect;
    logic                  leg_rev;
    logic                  ev_done;
    logic                  ev_fault;
    logic [PDS_IRQ_W-1:0]  irq_st_r;
    logic [PDS_IRQ_W-1:0]  irq_msk_r;
    logic [PDS_IRQ_W-1:0]  irq_set;
    logic [31:0]           status_w;
    logic [PDS_IRQ_W-1:0]  irq_st_nxt;
    logic                  ctrl_wr;
    logic                  irq_st_wr;
    logic                  irq_msk_wr;
    logic [31:0]           ctrl_w;

    // Register write decode, one strobe per writable register
    assign ctrl_wr    = bus_in.wr && (bus_in.addr == PDS_OFS_CTRL);
    assign irq_st_wr  = bus_in.wr && (bus_in.addr == PDS_OFS_IRQ_ST);
    assign irq_msk_wr = bus_in.wr && (bus_in.addr == PDS_OFS_IRQ_MSK);

    // Soft reset bit is a one-cycle pulse and is never stored
    assign soft_rst = ctrl_wr && bus_in.wdata[PDS_CTRL_SRST_BIT]; // R1

    // Detection policy, reset to detect at first servo-on
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pole_detect_policy_r <= PDS_POLICY_RST; // R7
        end else if (ctrl_wr) begin
            pole_detect_policy_r <= bus_in.wdata[PDS_CTRL_POLICY_LSB +: 4]; // R7
        end
    end

    // Stroke limit select for detection, reset to limits enabled
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pole_detect_stroke_limit_select_r <= PDS_STROKE_RST; // R10
        end else if (ctrl_wr) begin
            pole_detect_stroke_limit_select_r <= bus_in.wdata[PDS_CTRL_STROKE_BIT]; // R10
        end
    end

    // Encoder type, reset to incremental
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            abs_enc_r <= PDS_ABS_RST;
        end else if (ctrl_wr) begin
            abs_enc_r <= bus_in.wdata[PDS_CTRL_ABS_BIT];
        end
    end

    // Stroke end pins pass two flip-flops before use
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            lim_meta_r <= 2'h3;
            lim_sync_r <= 2'h3;
        end else begin
            lim_meta_r <= {forward_stroke_limit_in, reverse_stroke_limit_in};
            lim_sync_r <= lim_meta_r;
        end
    end

    // With limits disabled for detection both ends read as on
    assign fwd_off = !pole_detect_stroke_limit_select_r && !lim_sync_r[1]; // R10
    assign rev_off = !pole_detect_stroke_limit_select_r && !lim_sync_r[0]; // R10

    // Servo-on edge detect
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            servo_prev_r <= 1'b0;
        end else begin
            servo_prev_r <= servo_on_cmd_in;
        end
    end
    assign servo_rise = servo_on_cmd_in && !servo_prev_r;

    // Pending flag: set by power-up and soft reset, cleared on completion
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pending_r <= 1'b1; // R1
        end else if (soft_rst) begin
            pending_r <= 1'b1; // R1
        end else if (ev_done) begin
            pending_r <= 1'b0;
        end
    end

    // Decide whether this servo-on runs detection
    always_comb begin
        if (!abs_enc_r) begin
            need_detect = pending_r; // R2
        end else begin
            case (pole_detect_policy_r)
                PDS_POLICY_OFF:   need_detect = 1'b0; // R8
                PDS_POLICY_EVERY: need_detect = 1'b1; // R7
                default:          need_detect = pending_r; // R7
            endcase
        end
    end

    // Current leg runs into a stroke end that is off
    assign leg_rev = (dir_r && fwd_off) || (!dir_r && rev_off);

    // Sequence state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PDS_IDLE: begin
                if (servo_rise) begin
                    if (!need_detect) begin
                        state_nxt = PDS_LOCK;
                    end else if (fwd_off && rev_off) begin
                        state_nxt = PDS_FAULT; // R4
                    end else if (fwd_off || rev_off) begin
                        state_nxt = PDS_TO_START; // R5
                    end else begin
                        state_nxt = PDS_RECIP;
                    end
                end
            end
            PDS_TO_START: begin
                if (fwd_off && rev_off) begin
                    state_nxt = PDS_FAULT; // R4
                end else if (move_done_in) begin
                    state_nxt = PDS_RECIP; // R5
                end
            end
            PDS_RECIP: begin
                if (fwd_off && rev_off) begin
                    state_nxt = PDS_FAULT; // R4
                end else if (move_done_in && (legs_r == PDS_LEGS - 4'h1)) begin
                    state_nxt = PDS_RETURN; // R6
                end
            end
            PDS_RETURN: begin
                if (fwd_off && rev_off) begin
                    state_nxt = PDS_FAULT; // R4
                end else if (move_done_in) begin
                    state_nxt = PDS_LOCK; // R6
                end
            end
            PDS_LOCK:  state_nxt = PDS_LOCK;
            PDS_FAULT: state_nxt = PDS_FAULT;
            default:   state_nxt = PDS_IDLE;
        endcase
        // Servo-off drops back to idle except from a fault
        if (!servo_on_cmd_in && (state_r != PDS_FAULT)) begin
            state_nxt = PDS_IDLE;
        end
        // Soft reset returns any state to idle, fault included
        if (soft_rst) begin
            state_nxt = PDS_IDLE;
        end
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state_r <= PDS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Completion and fault events
    assign ev_done  = (state_r == PDS_RETURN) && (state_nxt == PDS_LOCK);
    assign ev_fault = (state_r != PDS_FAULT) && (state_nxt == PDS_FAULT);

    // Leg counter: completed legs of the reciprocation, cleared in idle
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            legs_r <= 4'h0;
        end else if (state_r == PDS_IDLE) begin
            legs_r <= 4'h0;
        end else if ((state_r == PDS_RECIP) && move_done_in) begin
            legs_r <= legs_r + 4'h1; // R6
        end
    end

    // Direction: away from an off end at start, flipped per leg or reversal
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            dir_r <= 1'b1;
        end else if (state_r == PDS_IDLE) begin
            dir_r <= !fwd_off; // R5
        end else if (state_r == PDS_RECIP) begin
            if (move_done_in) begin
                dir_r <= !dir_r; // R6
            end else if (leg_rev) begin
                dir_r <= !dir_r; // R3
            end
        end else if ((state_r == PDS_TO_START) && move_done_in) begin
            dir_r <= !dir_r; // R5
        end
    end

    // Motion outputs: home leg returns to the detection start position
    always_comb begin
        move_out      = '0;
        move_out.req  = (state_r == PDS_TO_START) || (state_r == PDS_RECIP) ||
                        (state_r == PDS_RETURN);
        move_out.dir  = dir_r;
        move_out.home = (state_r == PDS_RETURN); // R6
    end

    // Ready only in servo-lock, after detection done or skipped
    assign servo_ready_out    = (state_r == PDS_LOCK); // R11
    assign pos_cmd_accept_out = pos_cmd_in && (state_r == PDS_LOCK); // R11
    assign pole_detect_fault_alarm_out = (state_r == PDS_FAULT); // R4

    // Interrupt events
    always_comb begin
        irq_set = '0;
        irq_set[PDS_IRQ_DONE_BIT]  = ev_done;
        irq_set[PDS_IRQ_FAULT_BIT] = ev_fault;
        irq_set[PDS_IRQ_REV_BIT]   = (state_r == PDS_RECIP) && !move_done_in && leg_rev;
    end

    // Next sticky status per bit: its event wins over a written one
    for (genvar g = 0; g < PDS_IRQ_W; g++) begin : g_irq_bit
        assign irq_st_nxt[g] = irq_set[g] ||
                               (irq_st_r[g] && !(irq_st_wr && bus_in.wdata[g]));
    end

    // Sticky status, write one to clear
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= irq_st_nxt;
        end
    end

    // Interrupt mask
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            irq_msk_r <= PDS_IRQ_MSK_RST;
        end else if (irq_msk_wr) begin
            irq_msk_r <= bus_in.wdata[PDS_IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_st_r & irq_msk_r);

    // Status word
    always_comb begin
        status_w = '0;
        status_w[PDS_ST_STATE_LSB +: 6] = state_r;
        status_w[PDS_ST_PENDING_BIT]    = pending_r;
        status_w[PDS_ST_READY_BIT]      = (state_r == PDS_LOCK);
        status_w[PDS_ST_ALARM_BIT]      = (state_r == PDS_FAULT);
        status_w[PDS_ST_DIR_BIT]        = dir_r;
    end

    // Control readback; the soft reset bit always reads zero
    always_comb begin
        ctrl_w = '0;
        ctrl_w[PDS_CTRL_POLICY_LSB +: 4] = pole_detect_policy_r;
        ctrl_w[PDS_CTRL_STROKE_BIT]      = pole_detect_stroke_limit_select_r;
        ctrl_w[PDS_CTRL_ABS_BIT]         = abs_enc_r;
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                PDS_OFS_CTRL:    rdata_out <= ctrl_w;
                PDS_OFS_STATUS:  rdata_out <= status_w;
                PDS_OFS_IRQ_ST:  rdata_out <= {29'h0, irq_st_r};
                PDS_OFS_IRQ_MSK: rdata_out <= {29'h0, irq_msk_r};
                default:         rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end
endmodule
`default_nettype wire

//--- test_pds_sequencer.sv
// Self-checking bench for the pole detection sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module test_pds_sequencer;
    import pds_pkg::*;
    logic        clk      = 1'b0;
    logic        rstn     = 1'b0;
    pds_bus_s    bus      = '0;
    logic        servo_on = 1'b0;
    logic        pos_cmd  = 1'b0;
    logic        fwd      = 1'b1;
    logic        rev      = 1'b1;
    logic [7:0]  delay    = 8'h05;
    logic        saw_req  = 1'b0;
    logic        saw_home = 1'b0;
    logic [31:0] rdata;
    logic        accept, ready, alarm, irq, done;
    pds_move_s   move;
    int          fail_count  = 0;
    int          checks_done = 0;
    // Clock at 10 MHz
    always #50 clk = ~clk;
    // Note any commanded motion
    always @(posedge clk) begin
        if (move.req) saw_req <= 1'b1;
        if (move.home) saw_home <= 1'b1;
    end
    // Block under test and motion stage
    pds_sequencer i_pds_sequencer (.clock_in(clk), .rstn_in(rstn), .bus_in(bus), .rdata_out(rdata),
        .servo_on_cmd_in(servo_on), .pos_cmd_in(pos_cmd), .pos_cmd_accept_out(accept),
        .servo_ready_out(ready), .forward_stroke_limit_in(fwd), .reverse_stroke_limit_in(rev),
        .move_out(move), .move_done_in(done), .pole_detect_fault_alarm_out(alarm), .irq_out(irq));
    pds_motion_model i_pds_motion_model (.clock_in(clk), .rstn_in(rstn), .move_in(move),
        .delay_in(delay), .move_done_out(done));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_ready;
        for (int i = 0; i < 300 && ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    // Soft reset, configure, then raise servo-on afresh
    task automatic start_detect(input logic [31:0] cfg);
        wr(PDS_OFS_CTRL, 32'h100);
        wr(PDS_OFS_CTRL, cfg);
        servo_on <= 1'b0;
        tick(2);
        saw_req <= 1'b0;
        saw_home <= 1'b0;
        servo_on <= 1'b1;
        tick(3);
        #1;
    endtask
    task automatic run_servo(input logic [31:0] cfg, input logic exp);
        start_detect(cfg);
        wait_ready();
        `CHK(ready, 1'b1)
        `CHK(saw_req, exp)
        `CHK(saw_home, exp)
    endtask
    // Drop and raise servo-on again with no soft reset in between
    task automatic resume_servo(input logic exp);
        @(posedge clk);
        servo_on <= 1'b0;
        tick(2);
        saw_req <= 1'b0;
        saw_home <= 1'b0;
        servo_on <= 1'b1;
        wait_ready();
        `CHK(ready, 1'b1)
        `CHK(saw_req, exp)
    endtask
    task automatic t_reset_regs;
        logic [31:0] d;
        rd(PDS_OFS_CTRL, d);
        `CHK(d, 32'h1)
        rd(PDS_OFS_STATUS, d);
        `CHK(d[8], 1'b1)
        rd(8'h10, d);
        `CHK(d, 32'h0)
    endtask
    task automatic t_first_detect;
        logic [31:0] d;
        wr(PDS_OFS_IRQ_MSK, 32'h7);
        pos_cmd <= 1'b1;
        servo_on <= 1'b1;
        tick(3);
        #1;
        `CHK(move.req, 1'b1)
        `CHK(accept, 1'b0)
        wait_ready();
        `CHK(accept, 1'b1)
        `CHK(irq, 1'b1)
        rd(PDS_OFS_STATUS, d);
        `CHK(d[9:8], 2'h2)
        wr(PDS_OFS_IRQ_ST, 32'h7);
        tick(1);
        #1;
        `CHK(irq, 1'b0)
        @(posedge clk);
        pos_cmd <= 1'b0;
    endtask
    task automatic t_policy;
        logic [31:0] cfg[5] = '{32'h25, 32'h21, 32'h20, 32'h1, 32'h0};
        logic        exp[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic        again[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++) begin
            run_servo(cfg[i], exp[i]);
            resume_servo(again[i]);
        end
    endtask
    task automatic t_one_end;
        logic [31:0] d;
        @(posedge clk);
        delay <= 8'h28;
        fwd <= 1'b0;
        start_detect(32'h1);
        `CHK(move.dir, 1'b0)
        rd(PDS_OFS_STATUS, d);
        `CHK(d[5:0], 6'h02)
        @(posedge clk);
        fwd <= 1'b1;
        wait_ready();
        `CHK(ready, 1'b1)
    endtask
    task automatic t_reversal;
        logic [31:0] d;
        start_detect(32'h1);
        @(posedge clk);
        fwd <= 1'b0;
        tick(4);
        #1;
        `CHK({move.req, move.dir}, 2'h2)
        @(posedge clk);
        fwd <= 1'b1;
        wait_ready();
        rd(PDS_OFS_IRQ_ST, d);
        `CHK(d[2], 1'b1)
    endtask
    task automatic t_fault;
        start_detect(32'h1);
        wr(PDS_OFS_IRQ_MSK, 32'h7);
        fwd <= 1'b0;
        rev <= 1'b0;
        tick(4);
        #1;
        `CHK({alarm, ready, irq}, 3'h5)
        @(posedge clk);
        servo_on <= 1'b0;
        wr(PDS_OFS_IRQ_MSK, 32'h0);
        tick(1);
        #1;
        `CHK({alarm, irq}, 2'h2)
        @(posedge clk);
        fwd <= 1'b1;
        rev <= 1'b1;
        wr(PDS_OFS_CTRL, 32'h100);
        #1;
        `CHK(alarm, 1'b0)
    endtask
    task automatic t_no_limits;
        @(posedge clk);
        delay <= 8'h05;
        fwd <= 1'b0;
        rev <= 1'b0;
        run_servo(32'h11, 1'b1);
        `CHK(alarm, 1'b0)
        @(posedge clk);
        fwd <= 1'b1;
        rev <= 1'b1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        rstn <= 1'b1;
        t_reset_regs();
        t_first_detect();
        t_policy();
        t_one_end();
        t_reversal();
        t_fault();
        t_no_limits();
        stop_test();
    end
    // Watchdog against a hang
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
